/* File: rtl/gtw_formatter.sv */
// Formatter end: group builder, code translation and strobed line driver
`timescale 1ns/1ps

module gtw_formatter
    import gtw_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    gtw_tape_if.formatter             link,
    input  wire logic [BYTE_W-1:0]    in_data,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic                 pe_mode,
    input  wire logic                 tbl_we,
    input  wire logic [NIB_W-1:0]     tbl_addr,
    input  wire logic [CODE_W-1:0]    tbl_data,
    output logic                      busy
);
    gtw_state_e       state;
    gtw_byte_t        fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;
    gtw_byte_t        bytes [GROUP_BYTES];
    logic [2:0]       byte_idx;
    logic [3:0]       char_idx;
    logic [3:0]       last_char;
    logic [CNT_W-1:0] cnt;
    logic             pe_q;
    gtw_char_t        out_chars [STORE_CHARS];
    logic [CODE_W-1:0] code_tbl [TBL_DEPTH];
    gtw_byte_t        ecc;
    logic [DATA_CHARS*CHAR_W-1:0]  data_bits;
    logic [STORE_CHARS*CHAR_W-1:0] store_bits;
    gtw_char_t        line_data;
    logic             line_strobe;
    logic             line_density;

    // Bytes wait here while a group is being coded and sent
    gtw_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_data   (in_data),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Pop only while collecting; the sender stalls the FIFO otherwise
    assign fifo_pop = (state == GTW_FETCH) && fifo_valid;

    // Lines pass straight out here; the line drivers below invert, so a true bit drives the wire low
    assign link.data_n                 = line_data;
    assign link.write_char_strobe_n    = line_strobe;
    assign link.density_phase_select_n = line_density;

    // Loadable code table; contents come from the user, reset clears every entry to TBL_RST
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < TBL_DEPTH; i++) begin
                code_tbl[i] <= TBL_RST;
            end
        end else if (tbl_we) begin
            code_tbl[tbl_addr] <= tbl_data;
        end
    end

    // Check byte: running XOR of the seven data bytes
    always_comb begin
        ecc = '0;
        for (int i = 0; i < GROUP_BYTES; i++) begin
            ecc = ecc ^ bytes[i];
        end
    end

    // Odd parity on top of each byte; nibbles 0-8 and 9-17 form the subgroups
    always_comb begin
        data_bits = '0;
        for (int i = 0; i < DATA_CHARS; i++) begin
            if (i < GROUP_BYTES) begin
                data_bits[i*CHAR_W +: CHAR_W] = {~^bytes[i], bytes[i]};
            end else begin
                data_bits[i*CHAR_W +: CHAR_W] = {~^ecc, ecc};
            end
        end
    end

    // Every nibble goes through the table, parity and check bits included
    always_comb begin
        store_bits = '0;
        for (int n = 0; n < GROUP_NIBS; n++) begin
            store_bits[n*CODE_W +: CODE_W] = code_tbl[data_bits[n*NIB_W +: NIB_W]];
        end
    end

    // Sequencer: collect, encode, then one setup-strobe-hold per character
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state     <= GTW_IDLE;
            byte_idx  <= '0;
            char_idx  <= '0;
            last_char <= '0;
            cnt       <= '0;
            pe_q      <= 1'b0;
        end else begin
            case (state)
                GTW_IDLE: begin
                    pe_q     <= pe_mode;      // Mode only changes between groups
                    byte_idx <= '0;
                    if (fifo_valid) begin
                        state <= GTW_FETCH;
                    end
                end
                GTW_FETCH: begin
                    if (fifo_valid) begin
                        byte_idx <= byte_idx + 1'b1;
                        if (pe_q || byte_idx == 3'(GROUP_BYTES - 1)) begin
                            state <= GTW_ENCODE;
                        end
                    end
                end
                GTW_ENCODE: begin
                    char_idx  <= '0;
                    cnt       <= '0;
                    last_char <= pe_q ? 4'(PE_SENDS - 1) : 4'(STORE_CHARS - 1);
                    state     <= GTW_SETUP;
                end
                GTW_SETUP: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(SETUP_CYC - 1)) begin
                        cnt   <= '0;
                        state <= GTW_STROBE;
                    end
                end
                GTW_STROBE: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(STROBE_CYC - 1)) begin
                        cnt   <= '0;
                        state <= GTW_HOLD;
                    end
                end
                GTW_HOLD: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(HOLD_CYC - 1)) begin
                        cnt <= '0;
                        if (char_idx == last_char) begin
                            state <= GTW_IDLE;
                        end else begin
                            char_idx <= char_idx + 1'b1;
                            state    <= GTW_SETUP;
                        end
                    end
                end
                default: begin
                    state <= GTW_IDLE;
                end
            endcase
        end
    end

    // Byte capture from the FIFO
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < GROUP_BYTES; i++) begin
                bytes[i] <= '0;
            end
        end else if (fifo_pop) begin
            bytes[byte_idx] <= fifo_data;
        end
    end

    // Character buffer; phase encoded sends the same character twice
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int k = 0; k < STORE_CHARS; k++) begin
                out_chars[k] <= '0;
            end
        end else if (state == GTW_ENCODE) begin
            for (int k = 0; k < STORE_CHARS; k++) begin
                if (pe_q) begin
                    out_chars[k] <= {~^bytes[0], bytes[0]};
                end else begin
                    out_chars[k] <= store_bits[k*CHAR_W +: CHAR_W];
                end
            end
        end
    end

    // Line drivers; data held through setup, strobe and hold windows
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            line_data    <= LINE_IDLE;
            line_strobe  <= 1'b1;
            line_density <= 1'b1;
        end else begin
            line_density <= ~pe_q;
            line_strobe  <= ~(state == GTW_STROBE);
            if (state == GTW_SETUP && cnt == '0) begin
                line_data <= ~out_chars[char_idx];
            end else if (state == GTW_IDLE) begin
                line_data <= LINE_IDLE;
            end
        end
    end

    // Busy covers the whole group, so the user can see when lines are quiet
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= state != GTW_IDLE;
        end
    end
endmodule

/* File: rtl/gtw_pkg.sv */
// Package: shared constants and types for the tape write encoding path
package gtw_pkg;

    // Clock and interface timing
    localparam int CLK_NS        = 10;
    localparam int STROBE_MIN_NS = 1000;
    localparam int SETUP_MIN_NS  = 500;
    localparam int HOLD_MIN_NS   = 500;
    localparam int STROBE_CYC    = (STROBE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC     = (SETUP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC      = (HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 8;

    // Group layout
    localparam int BYTE_W        = 8;
    localparam int CHAR_W        = 9;
    localparam int GROUP_BYTES   = 7;
    localparam int DATA_CHARS    = 8;
    localparam int STORE_CHARS   = 10;
    localparam int NIB_W         = 4;
    localparam int CODE_W        = 5;
    localparam int SUB_NIBS      = 9;
    localparam int GROUP_NIBS    = 2 * SUB_NIBS;
    localparam int TBL_DEPTH     = 16;
    localparam int PE_SENDS      = 2;
    localparam int FIFO_DEPTH    = 32;

    // Reset values
    localparam logic [CHAR_W-1:0] HEAD_RST = 9'h000;
    localparam logic [CHAR_W-1:0] LINE_IDLE = 9'h1ff;
    localparam logic [CODE_W-1:0] TBL_RST  = 5'h00;

    typedef logic [CHAR_W-1:0] gtw_char_t;
    typedef logic [BYTE_W-1:0] gtw_byte_t;

    // Formatter sequence, Gray coded from GTW_IDLE through GTW_HOLD; the steps back to GTW_SETUP and GTW_IDLE are not
    typedef enum logic [2:0] {
        GTW_IDLE   = 3'h0,
        GTW_FETCH  = 3'h1,
        GTW_ENCODE = 3'h3,
        GTW_SETUP  = 3'h2,
        GTW_STROBE = 3'h6,
        GTW_HOLD   = 3'h7
    } gtw_state_e;

endpackage

/* File: rtl/gtw_tape_if.sv */
// Interface: parallel low-true write lines between formatter and transport
`timescale 1ns/1ps
interface gtw_tape_if (
    input wire logic mclk
);
    logic [8:0] data_n;
    logic       write_char_strobe_n;
    logic       density_phase_select_n;

    modport formatter (
        output data_n,
        output write_char_strobe_n,
        output density_phase_select_n
    );

    modport transport (
        input data_n,
        input write_char_strobe_n,
        input density_phase_select_n
    );
endinterface

/* File: rtl/gtw_transport.sv */
// Transport end: head write levels, plus the byte FIFO used by the formatter
`timescale 1ns/1ps

module gtw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Occupancy; flags kept in flops so the ready seen upstream is clean
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count     <= next_count;
            in_ready  <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end

    // Pointers wrap naturally because depth is a power of two
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Storage needs no reset; contents are only read behind out_valid
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module gtw_transport
    import gtw_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     reset_n,
    gtw_tape_if.transport link,
    output gtw_char_t     head_drive,
    output logic          char_taken,
    output logic          pe_active
);
    logic      strobe_q;
    logic      trail;
    logic      pe_now;
    logic      half_q;
    gtw_char_t bits;

    // Wires are low-true; both ends share mclk so no resampling is needed
    assign bits   = ~link.data_n;
    assign pe_now = ~link.density_phase_select_n;
    assign trail  = !strobe_q && link.write_char_strobe_n;

    // Strobe history for trailing-edge detection
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= link.write_char_strobe_n;
        end
    end

    // Half-cell phase; a mode change restarts at the first half
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            half_q    <= 1'b0;
            pe_active <= 1'b0;
        end else begin
            pe_active <= pe_now;
            if (pe_now != pe_active || !pe_now) begin
                half_q <= 1'b0;
            end else if (trail) begin
                half_q <= ~half_q;
            end
        end
    end

    // Head level, 1 = erase direction. Phase encoded: first half opposite,
    // second half final, so the data edge lands mid-cell and equal
    // neighbours force a boundary edge.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            head_drive <= HEAD_RST;
            char_taken <= 1'b0;
        end else begin
            char_taken <= trail;
            if (trail) begin
                if (pe_now) begin
                    if (!half_q) begin
                        head_drive <= ~bits;
                    end else begin
                        head_drive <= bits;
                    end
                end else begin
                    head_drive <= head_drive ^ bits;
                end
            end
        end
    end
endmodule

/* File: sim/gtw_assertions.sv */
// Checker: timing and framing relations on the formatter-to-transport lines
`timescale 1ns/1ps
module gtw_assertions (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic [8:0] data_n,
    input wire logic       write_char_strobe_n,
    input wire logic       density_phase_select_n
);
    logic [7:0] low_cnt;
    logic [7:0] stab_cnt;
    logic [7:0] rise_cnt;
    logic [8:0] d_q;
    logic [8:0] first_char;
    logic       s_q;
    logic       pe_half;
    logic       falls;
    logic       moved;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Edge and change detects against the previous sample
    assign falls = s_q && !write_char_strobe_n;
    assign moved = data_n != d_q;

    // stab_cnt and rise_cnt saturate, so long idle stretches never wrap into a false pass; low_cnt wraps
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_q        <= 1'b1;
            d_q        <= 9'h1ff;
            low_cnt    <= 8'h00;
            stab_cnt   <= 8'h00;
            rise_cnt   <= 8'hff;
            pe_half    <= 1'b0;
            first_char <= 9'h000;
        end else begin
            s_q      <= write_char_strobe_n;
            d_q      <= data_n;
            low_cnt  <= write_char_strobe_n ? 8'h00 : low_cnt + 8'h01;
            stab_cnt <= moved ? 8'h00 : stab_cnt + {7'h00, stab_cnt != 8'hff};
            rise_cnt <= !write_char_strobe_n ? 8'h00 : rise_cnt + {7'h00, rise_cnt != 8'hff};
            if (density_phase_select_n)
                pe_half <= 1'b0;
            else if (falls)
                pe_half <= !pe_half;
            if (falls && !pe_half)
                first_char <= data_n;
        end
    end

    property p_low_width;
        $rose(write_char_strobe_n) |-> low_cnt == 8'h64;
    endproperty
    a_low_width: assert property (p_low_width)
        else $error("strobe low time is not 100 cycles");

    property p_data_low;
        !write_char_strobe_n |-> !moved;
    endproperty
    a_data_low: assert property (p_data_low)
        else $error("data lines moved while strobe was low");

    property p_setup;
        $fell(write_char_strobe_n) |-> stab_cnt >= 8'h31;
    endproperty
    a_setup: assert property (p_setup)
        else $error("data not steady 50 cycles before strobe");

    property p_hold;
        moved |-> write_char_strobe_n && rise_cnt >= 8'h31;
    endproperty
    a_hold: assert property (p_hold)
        else $error("data moved within 50 cycles after strobe");

    property p_gap;
        falls |-> rise_cnt >= 8'h63;
    endproperty
    a_gap: assert property (p_gap)
        else $error("strobes closer than one character slot");

    property p_density;
        $changed(density_phase_select_n) |-> write_char_strobe_n && rise_cnt >= 8'h31;
    endproperty
    a_density: assert property (p_density)
        else $error("density select moved inside a character");

    property p_pe_parity;
        falls && !density_phase_select_n |-> ^(~data_n);
    endproperty
    a_pe_parity: assert property (p_pe_parity)
        else $error("phase encoded character lacks odd parity");

    property p_pe_pair;
        falls && !density_phase_select_n && pe_half |-> data_n == first_char;
    endproperty
    a_pe_pair: assert property (p_pe_pair)
        else $error("second phase encoded strobe carries another char");

    c_gcr_char: cover property ($rose(write_char_strobe_n) && density_phase_select_n);
    c_pe_pair: cover property (falls && !density_phase_select_n && pe_half);
    c_mode: cover property ($fell(density_phase_select_n));
endmodule

/* File: sim/tb_gcr_pe_tape_write_encoding.sv */
// Testbench: formatter and transport joined back to back over the tape lines
`timescale 1ns/1ps
module tb_gcr_pe_tape_write_encoding
    import gtw_pkg::*;
;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic [7:0] in_data;
    logic       in_valid, in_ready, pe_mode, tbl_we, busy, char_taken, pe_active, s_q;
    logic [3:0] tbl_addr;
    logic [4:0] tbl_data;
    logic [4:0] tbl [16];
    gtw_char_t  head_drive, cur, head_exp, exp_q[$];
    logic       pe_phase;
    int         n_errors, n_checks, n_rise, n_taken, n_full;

    always #5 mclk = ~mclk;

    gtw_tape_if i_gtw_tape_if (.mclk(mclk));
    gtw_formatter i_gtw_formatter (.mclk(mclk), .reset_n(reset_n), .link(i_gtw_tape_if),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .pe_mode(pe_mode),
        .tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_data(tbl_data), .busy(busy));
    gtw_transport i_gtw_transport (.mclk(mclk), .reset_n(reset_n), .link(i_gtw_tape_if),
        .head_drive(head_drive), .char_taken(char_taken), .pe_active(pe_active));
    gtw_assertions i_gtw_assertions (.mclk(mclk), .reset_n(reset_n),
        .data_n(i_gtw_tape_if.data_n),
        .write_char_strobe_n(i_gtw_tape_if.write_char_strobe_n),
        .density_phase_select_n(i_gtw_tape_if.density_phase_select_n));

    task automatic check_val(input gtw_char_t got, input gtw_char_t exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic timeout;
        n_errors++;
        $display("mismatch at %0t: wait limit reached, got %h expected %h", $time, 0, 1);
        tally_and_finish();
    endtask

    // Byte push; valid stays up so consecutive calls stream back to back
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        in_data = b;
        in_valid = 1'b1;
        if (in_ready !== 1'b1) n_full++;
        while (in_ready !== 1'b1 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 5000) timeout();
        @(negedge mclk);
    endtask

    task automatic load_tbl;
        for (int n = 0; n < 16; n++) begin
            @(negedge mclk);
            tbl_we = 1'b1;
            tbl_addr = 4'(n);
            tbl_data = 5'(n * 7 + 3);
            tbl[n] = tbl_data;
        end
        @(negedge mclk);
        tbl_we = 1'b0;
    endtask

    // Seven bytes, then the storage characters the lines must carry
    task automatic send_group(input logic [7:0] b0, input logic [7:0] step);
        logic [71:0] d;
        logic [89:0] s;
        logic [7:0]  b;
        logic [7:0]  e;
        e = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b = (i < 7) ? b0 + 8'(i) * step : e;
            d[9*i +: 9] = {~^b, b};
            e = e ^ b;
            if (i < 7) put(b);
        end
        for (int n = 0; n < 18; n++) s[5*n +: 5] = tbl[d[4*n +: 4]];
        for (int k = 0; k < 10; k++) exp_q.push_back(s[9*k +: 9]);
    endtask

    task automatic send_pe(input logic [7:0] b);
        exp_q.push_back({~^b, b});
        exp_q.push_back({~^b, b});
        put(b);
    endtask

    task automatic wait_done(input string name);
        int n;
        n = 0;
        in_valid = 1'b0;
        while ((exp_q.size() != 0 || busy !== 1'b0) && n < 30000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 30000) timeout();
        repeat (4) @(negedge mclk);
        check_val(9'(n_taken), 9'(n_rise));
        $display("test %s done", name);
    endtask

    // Line monitor; the head model follows the recording rules of each mode
    always @(negedge mclk) begin
        if (reset_n === 1'b1 && char_taken === 1'b1) begin
            n_taken++;
            check_val(head_drive, head_exp);
            check_val({8'h00, pe_active}, {8'h00, pe_mode});
        end
        if (reset_n === 1'b1 && s_q === 1'b0 && i_gtw_tape_if.write_char_strobe_n === 1'b1) begin
            n_rise++;
            cur = ~i_gtw_tape_if.data_n;
            if (exp_q.size() == 0) exp_q.push_back(~cur); // An extra char is a fault
            check_val(cur, exp_q.pop_front());
            check_val({8'h00, i_gtw_tape_if.density_phase_select_n}, {8'h00, !pe_mode});
            if (pe_mode) begin
                head_exp = pe_phase ? cur : ~cur;
                pe_phase = ~pe_phase;
            end else begin
                head_exp = head_exp ^ cur;
                pe_phase = 1'b0;
            end
        end
        s_q = i_gtw_tape_if.write_char_strobe_n;
    end

    initial begin
        in_data = 8'h00;
        in_valid = 1'b0;
        pe_mode = 1'b0;
        tbl_we = 1'b0;
        tbl_addr = 4'h0;
        tbl_data = 5'h00;
        head_exp = HEAD_RST;
        pe_phase = 1'b0;
        repeat (8) @(negedge mclk);
        check_val(i_gtw_tape_if.data_n, LINE_IDLE);
        check_val({8'h00, i_gtw_tape_if.write_char_strobe_n}, 9'h001);
        check_val(head_drive, HEAD_RST);
        check_val({8'h00, in_ready}, 9'h000);
        reset_n = 1'b1;
        $display("test reset done");
        load_tbl();
        send_group(8'h00, 8'h11);
        send_group(8'hff, 8'h00);
        wait_done("gcr");
        pe_mode = 1'b1;
        send_pe(8'h5a);
        send_pe(8'h5a);
        send_pe(8'h00);
        send_pe(8'hff);
        wait_done("pe");
        pe_mode = 1'b0;
        n_full = 0;
        for (int g = 0; g < 7; g++) send_group(8'(g * 37), 8'h03);
        check_val(9'(n_full > 0), 9'h001);
        wait_done("fifo");
        tally_and_finish();
    end
endmodule
